// File: pkg/atmh_pkg.sv
/*
  Shared constants and types for the test cell header register block.
  Assumes one 20 MHz system clock shared by software and the cell
  processors.
*/
// Notes on behaviour
// - Index 0x37 holds generator 3 header byte 1 in bits 15:8 and byte 2 in bits 7:0.
// - Indices 0x38, 0x39 and 0x3A hold bytes 1 and 2 of generators 2, 1 and 0.
// - Indices 0x3B and 0x3C hold bytes 3 and 4 of generators 3 and 2, byte 3 high.
// - Indices 0x3D and 0x3E hold bytes 3 and 4 of generators 1 and 0, byte 3 high.
// - An enabled generator puts a test cell with its header in place of an idle cell.
// - Generators 1 to 3 and analyzer 3 act only in four-channel mode.
// - Generator 0 acts in both four-channel and concatenated mode.
// - Every header register here is read/write and resets to zero.
// - Index 0x3F holds analyzer 3 expected bytes 1 and 2, byte 1 high.
// - Receive processor 3 flags a cell whose header equals the expected pattern.

package atmh_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NCH    = 4;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_TX12 [NCH] = '{6'h3A, 6'h39, 6'h38, 6'h37};
  localparam logic [5:0] IDX_TX34 [NCH] = '{6'h3E, 6'h3D, 6'h3C, 6'h3B};
  localparam logic [5:0] IDX_RX12      = 6'h3F;
  localparam logic [5:0] IDX_FIRST     = 6'h37;

  // ---------------------------------------------------------------
  // field positions, reset values, answers
  // ---------------------------------------------------------------
  localparam int unsigned HI_LSB      = 8;
  localparam logic [15:0] HDR_RST     = 16'h0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
  } atmh_hdr_type;

endpackage : atmh_pkg

// File: hw/atmh_tx_gen.sv
/*
  One transmit test cell generator.
  Assumes cell_start pulses for one cycle at each cell boundary, with
  cell_idle telling whether that cell would otherwise be idle.
*/
`timescale 1ns/100ps
`default_nettype none

module atmh_tx_gen
  import atmh_pkg::*;
(
  // clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // cell slot
  input  wire logic          cell_start,
  input  wire logic          cell_idle,
  input  wire logic          gen_en,
  input  wire logic          chan_on,
  // programmed header
  input  wire atmh_pkg::atmh_hdr_type hdr_reg,
  // test cell out
  output logic               test_sel,
  output atmh_pkg::atmh_hdr_type test_hdr
);

  logic         sel_ff;
  atmh_hdr_type hdr_ff;

  // ---------------------------------------------------------------
  // header taken only at the boundary
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hdr_ff <= '0;
    end else if (cell_start) begin
      hdr_ff <= hdr_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_ff <= 1'b0;
    end else if (cell_start) begin
      sel_ff <= gen_en & cell_idle & chan_on;
    end
  end

  // bytes leave in order b1, b2, b3, b4
  assign test_hdr = hdr_ff;
  assign test_sel = sel_ff & chan_on;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_sel_cause;
    @(posedge aclk) disable iff (!aresetn)
    (cell_start && chan_on) |=> (sel_ff == $past(gen_en && cell_idle));
  endproperty
  a_sel_cause: assert property (p_sel_cause) else $error("test cell choice wrong");

  property p_hdr_hold;
    @(posedge aclk) disable iff (!aresetn)
    !cell_start |=> $stable(test_hdr);
  endproperty
  a_hdr_hold: assert property (p_hdr_hold) else $error("header moved inside a cell");

endmodule : atmh_tx_gen

`default_nettype wire

// File: hw/atmh_rx_cmp.sv
/*
  Test cell recogniser for receive cell processor 3.
  Assumes cell_start marks each boundary and hdr_valid pulses once the
  four received header bytes stand on cell_hdr.
*/
`timescale 1ns/100ps
`default_nettype none

module atmh_rx_cmp
  import atmh_pkg::*;
(
  // clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // received cell
  input  wire logic          cell_start,
  input  wire logic          hdr_valid,
  input  wire atmh_pkg::atmh_hdr_type cell_hdr,
  input  wire logic          chan_on,
  // expected pattern
  input  wire atmh_pkg::atmh_hdr_type exp_reg,
  // verdict
  output logic               test_valid,
  output logic               test_cell
);

  atmh_hdr_type exp_ff;
  logic         valid_ff;
  logic         match_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exp_ff <= '0;
    end else if (cell_start) begin
      exp_ff <= exp_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      valid_ff <= 1'b0;
      match_ff <= 1'b0;
    end else begin
      valid_ff <= hdr_valid;
      if (hdr_valid) begin
        match_ff <= chan_on && (cell_hdr == exp_ff);
      end
    end
  end

  assign test_valid = valid_ff;
  assign test_cell  = match_ff;

  property p_match;
    @(posedge aclk) disable iff (!aresetn)
    hdr_valid |=> test_valid && (test_cell == ($past(chan_on) && $past(cell_hdr) == $past(exp_ff)));
  endproperty
  a_match: assert property (p_match) else $error("test cell verdict wrong");

endmodule : atmh_rx_cmp

`default_nettype wire

// File: hw/atmh_hdr_regs.sv
/*
  Test cell header registers with an AXI4-Lite slave, four transmit
  test cell generators and the receive analyzer 3 recogniser.
  Assumes the cell processors run on aclk; enable bits, mode and the
  analyzer 3 bytes 3/4 register come in as plain inputs.
*/
`timescale 1ns/100ps
`default_nettype none

module atmh_hdr_regs (
  // clock and reset
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // axi4-lite write address
  input  wire logic [atmh_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  // axi4-lite write data
  input  wire logic [atmh_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  // axi4-lite read
  input  wire logic [atmh_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [atmh_pkg::DATA_W-1:0]   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // mode
  input  wire logic                     concat_mode,
  // transmit cell processors
  input  wire logic [atmh_pkg::NCH-1:0] tx_cell_start,
  input  wire logic [atmh_pkg::NCH-1:0] tx_cell_idle,
  input  wire logic [atmh_pkg::NCH-1:0] tx_gen_en,
  output logic [atmh_pkg::NCH-1:0]      tx_test_sel,
  output atmh_pkg::atmh_hdr_type        tx_test_hdr [atmh_pkg::NCH],
  // receive cell processor 3
  input  wire logic                     rx3_cell_start,
  input  wire logic                     rx3_hdr_valid,
  input  wire atmh_pkg::atmh_hdr_type   rx3_cell_hdr,
  input  wire logic [15:0]              rx3_exp_bytes_3_4,
  output logic                          rx3_test_valid,
  output logic                          rx3_test_cell
);
  import atmh_pkg::*;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [15:0]       tx12_ff [NCH];
  logic [15:0]       tx34_ff [NCH];
  logic [15:0]       rx12_ff;

  logic              aw_held_ff;
  logic              w_held_ff;
  logic [5:0]        wr_idx_ff;
  logic [15:0]       wdata_ff;
  logic [1:0]        wstrb_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              rvalid_ff;
  logic [1:0]        rresp_ff;
  logic [15:0]       rdata_ff;

  logic              wr_fire;
  logic              aw_fire;
  logic              w_fire;
  logic              ar_fire;
  logic [5:0]        ar_idx;
  logic [NCH-1:0]    chan_on;

  // ---------------------------------------------------------------
  // address helpers
  // ---------------------------------------------------------------
  function automatic logic idx_mapped(input logic [5:0] idx);
    idx_mapped = (idx >= IDX_FIRST) && (idx <= IDX_RX12);
  endfunction : idx_mapped

  // ---------------------------------------------------------------
  // write channel capture, either order
  // ---------------------------------------------------------------
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready  = !w_held_ff && !bvalid_ff;
  assign aw_fire       = s_axi_awvalid && s_axi_awready;
  assign w_fire        = s_axi_wvalid && s_axi_wready;
  assign wr_fire       = aw_held_ff && w_held_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      wr_idx_ff  <= '0;
    end else if (aw_fire) begin
      aw_held_ff <= 1'b1;
      wr_idx_ff  <= s_axi_awaddr[ADDR_W-1:2];
    end else if (wr_fire) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_ff <= 1'b0;
      wdata_ff  <= '0;
      wstrb_ff  <= '0;
    end else if (w_fire) begin
      w_held_ff <= 1'b1;
      wdata_ff  <= s_axi_wdata[15:0];
      wstrb_ff  <= s_axi_wstrb[1:0];
    end else if (wr_fire) begin
      w_held_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // write response
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= idx_mapped(wr_idx_ff) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;

  // ---------------------------------------------------------------
  // header registers, one pair per generator
  // ---------------------------------------------------------------
  generate
    for (genvar c = 0; c < NCH; c++) begin : g_txreg
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          tx12_ff[c] <= HDR_RST;
        end else if (wr_fire && wr_idx_ff == IDX_TX12[c]) begin
          if (wstrb_ff[1]) begin
            tx12_ff[c][15:HI_LSB] <= wdata_ff[15:HI_LSB];
          end
          if (wstrb_ff[0]) begin
            tx12_ff[c][HI_LSB-1:0] <= wdata_ff[HI_LSB-1:0];
          end
        end
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          tx34_ff[c] <= HDR_RST;
        end else if (wr_fire && wr_idx_ff == IDX_TX34[c]) begin
          if (wstrb_ff[1]) begin
            tx34_ff[c][15:HI_LSB] <= wdata_ff[15:HI_LSB];
          end
          if (wstrb_ff[0]) begin
            tx34_ff[c][HI_LSB-1:0] <= wdata_ff[HI_LSB-1:0];
          end
        end
      end

      // channel 0 runs in both modes, the others only in four-channel
      assign chan_on[c] = (c == 0) ? 1'b1 : !concat_mode;

      atmh_tx_gen u_gen (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .cell_start (tx_cell_start[c]),
        .cell_idle  (tx_cell_idle[c]),
        .gen_en     (tx_gen_en[c]),
        .chan_on    (chan_on[c]),
        .hdr_reg    ({tx12_ff[c], tx34_ff[c]}),
        .test_sel   (tx_test_sel[c]),
        .test_hdr   (tx_test_hdr[c])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // analyzer 3 expected bytes 1 and 2
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx12_ff <= HDR_RST;
    end else if (wr_fire && wr_idx_ff == IDX_RX12) begin
      if (wstrb_ff[1]) begin
        rx12_ff[15:HI_LSB] <= wdata_ff[15:HI_LSB];
      end
      if (wstrb_ff[0]) begin
        rx12_ff[HI_LSB-1:0] <= wdata_ff[HI_LSB-1:0];
      end
    end
  end

  atmh_rx_cmp u_rx3 (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .cell_start (rx3_cell_start),
    .hdr_valid  (rx3_hdr_valid),
    .cell_hdr   (rx3_cell_hdr),
    .chan_on    (chan_on[NCH-1]),
    .exp_reg    ({rx12_ff, rx3_exp_bytes_3_4}),
    .test_valid (rx3_test_valid),
    .test_cell  (rx3_test_cell)
  );

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  assign s_axi_arready = !rvalid_ff;
  assign ar_fire       = s_axi_arvalid && s_axi_arready;
  assign ar_idx        = s_axi_araddr[ADDR_W-1:2];

  function automatic logic [15:0] rd_word(input logic [5:0] idx);
    rd_word = '0;
    for (int c = 0; c < NCH; c++) begin
      if (idx == IDX_TX12[c]) begin
        rd_word = tx12_ff[c];
      end
      if (idx == IDX_TX34[c]) begin
        rd_word = tx34_ff[c];
      end
    end
    if (idx == IDX_RX12) begin
      rd_word = rx12_ff;
    end
  endfunction : rd_word

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= RESP_OKAY;
      rdata_ff  <= '0;
    end else if (ar_fire) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= idx_mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
      rdata_ff  <= rd_word(ar_idx);
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // upper half reads as zero
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp  = rresp_ff;
  assign s_axi_rdata  = {16'h0000, rdata_ff};

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_wr_hi(logic [5:0] idx);
    wr_fire && wr_idx_ff == idx && wstrb_ff[1];
  endsequence

  sequence s_wr_lo(logic [5:0] idx);
    wr_fire && wr_idx_ff == idx && wstrb_ff[0];
  endsequence

  property p_wr_g3_b1;
    @(posedge aclk) disable iff (!aresetn)
    s_wr_hi(6'h37) |=> tx12_ff[3][15:8] == $past(wdata_ff[15:8]);
  endproperty
  a_wr_g3_b1: assert property (p_wr_g3_b1) else $error("generator 3 byte 1 not stored");

  property p_wr_g0_b2;
    @(posedge aclk) disable iff (!aresetn)
    s_wr_lo(6'h3A) |=> tx12_ff[0][7:0] == $past(wdata_ff[7:0]);
  endproperty
  a_wr_g0_b2: assert property (p_wr_g0_b2) else $error("generator 0 byte 2 not stored");

  property p_wr_g2_b3;
    @(posedge aclk) disable iff (!aresetn)
    s_wr_hi(6'h3C) |=> tx34_ff[2][15:8] == $past(wdata_ff[15:8]);
  endproperty
  a_wr_g2_b3: assert property (p_wr_g2_b3) else $error("generator 2 byte 3 not stored");

  property p_wr_g1_b4;
    @(posedge aclk) disable iff (!aresetn)
    s_wr_lo(6'h3D) |=> tx34_ff[1][7:0] == $past(wdata_ff[7:0]);
  endproperty
  a_wr_g1_b4: assert property (p_wr_g1_b4) else $error("generator 1 byte 4 not stored");

  property p_wr_rx;
    @(posedge aclk) disable iff (!aresetn)
    s_wr_hi(6'h3F) |=> rx12_ff[15:8] == $past(wdata_ff[15:8]);
  endproperty
  a_wr_rx: assert property (p_wr_rx) else $error("analyzer byte 1 not stored");

  property p_reset_zero;
    @(posedge aclk)
    !aresetn |=> (rx12_ff == 16'h0000) && (tx12_ff[3] == 16'h0000) && (tx34_ff[0] == 16'h0000);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("header not zero after reset");

  property p_read_back;
    @(posedge aclk) disable iff (!aresetn)
    (ar_fire && ar_idx == 6'h3B) |=> s_axi_rvalid && s_axi_rdata == {16'h0000, $past(tx34_ff[3])};
  endproperty
  a_read_back: assert property (p_read_back) else $error("read data wrong");

  property p_concat_off;
    @(posedge aclk) disable iff (!aresetn)
    concat_mode |-> tx_test_sel[3:1] == 3'h0;
  endproperty
  a_concat_off: assert property (p_concat_off) else $error("test cell in concatenated mode");

  property p_ch0_both;
    @(posedge aclk) disable iff (!aresetn)
    (tx_cell_start[0] && tx_gen_en[0] && tx_cell_idle[0]) |=> tx_test_sel[0] [*1];
  endproperty
  a_ch0_both: assert property (p_ch0_both) else $error("generator 0 silent");

  property p_bresp;
    @(posedge aclk) disable iff (!aresetn)
    wr_fire |=> s_axi_bvalid && (s_axi_bresp == RESP_SLVERR) == !idx_mapped($past(wr_idx_ff));
  endproperty
  a_bresp: assert property (p_bresp) else $error("write answer wrong");

endmodule : atmh_hdr_regs

`default_nettype wire

// File: sim/atmh_hdr_regs_tb.sv
/*
  Self-checking testbench for the test cell header register block.
  Assumes the block answers on AXI4-Lite at byte address four times the
  register index, and that cell slots come as one-cycle pulses on aclk.
*/
`timescale 1ns/100ps
`default_nettype none

module atmh_hdr_regs_tb;
  import atmh_pkg::*;

  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic                aclk;
  logic                aresetn;
  logic [ADDR_W-1:0]   s_axi_awaddr;
  logic                s_axi_awvalid;
  logic                s_axi_awready;
  logic [DATA_W-1:0]   s_axi_wdata;
  logic [3:0]          s_axi_wstrb;
  logic                s_axi_wvalid;
  logic                s_axi_wready;
  logic [1:0]          s_axi_bresp;
  logic                s_axi_bvalid;
  logic                s_axi_bready;
  logic [ADDR_W-1:0]   s_axi_araddr;
  logic                s_axi_arvalid;
  logic                s_axi_arready;
  logic [DATA_W-1:0]   s_axi_rdata;
  logic [1:0]          s_axi_rresp;
  logic                s_axi_rvalid;
  logic                s_axi_rready;
  logic                concat_mode;
  logic [NCH-1:0]      tx_cell_start;
  logic [NCH-1:0]      tx_cell_idle;
  logic [NCH-1:0]      tx_gen_en;
  logic [NCH-1:0]      tx_test_sel;
  atmh_hdr_type        tx_test_hdr [NCH];
  logic                rx3_cell_start;
  logic                rx3_hdr_valid;
  atmh_hdr_type        rx3_cell_hdr;
  logic [15:0]         rx3_exp_bytes_3_4;
  logic                rx3_test_valid;
  logic                rx3_test_cell;
  int                  num_errors;
  int                  checked;
  int                  cycles;
  logic [15:0]         exp12 [NCH];
  logic [15:0]         exp34 [NCH];

  atmh_hdr_regs i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .concat_mode(concat_mode),
    .tx_cell_start(tx_cell_start), .tx_cell_idle(tx_cell_idle), .tx_gen_en(tx_gen_en),
    .tx_test_sel(tx_test_sel), .tx_test_hdr(tx_test_hdr), .rx3_cell_start(rx3_cell_start),
    .rx3_hdr_valid(rx3_hdr_valid), .rx3_cell_hdr(rx3_cell_hdr),
    .rx3_exp_bytes_3_4(rx3_exp_bytes_3_4), .rx3_test_valid(rx3_test_valid),
    .rx3_test_cell(rx3_test_cell)
  );

  // ---------------------------------------------------------------
  // clock and hang guard
  // ---------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      finish_test();
    end
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // index to byte address
  function automatic logic [7:0] ba(input logic [7:0] idx);
    return idx << 2;
  endfunction : ba

  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] exp_resp);
    logic aw;
    logic w;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    aw = 1'b1;
    w  = 1'b1;
    forever begin
      @(posedge aclk);
      if (!aw && !w && s_axi_bvalid) begin
        check("bresp", {30'h0, s_axi_bresp}, {30'h0, exp_resp});
        s_axi_bready <= 1'b0;
        break;
      end
      if (aw && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        aw = 1'b0;
      end
      if (w && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        w = 1'b0;
      end
    end
  endtask : wr_chk

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] exp_resp);
    logic ar;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    ar = 1'b1;
    forever begin
      @(posedge aclk);
      if (!ar && s_axi_rvalid) begin
        check("rdata", s_axi_rdata, exp);
        check("rresp", {30'h0, s_axi_rresp}, {30'h0, exp_resp});
        s_axi_rready <= 1'b0;
        break;
      end
      if (ar && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        ar = 1'b0;
      end
    end
  endtask : rd_chk

  // one cell slot on all four transmit channels
  task automatic tx_cell(input logic [3:0] idle, input logic [3:0] en, input logic [3:0] exp_sel);
    @(posedge aclk);
    tx_cell_start <= 4'hF;
    tx_cell_idle  <= idle;
    tx_gen_en     <= en;
    @(posedge aclk);
    tx_cell_start <= 4'h0;
    #1;
    check("tx_test_sel", {28'h0, tx_test_sel}, {28'h0, exp_sel});
    for (int n = 0; n < NCH; n++) begin
      if (exp_sel[n]) begin
        check("tx_test_hdr", tx_test_hdr[n], {exp12[n], exp34[n]});
      end
    end
  endtask : tx_cell

  task automatic rx_cell(input logic [31:0] hdr, input logic exp_cell);
    @(posedge aclk);
    rx3_cell_start <= 1'b1;
    @(posedge aclk);
    rx3_cell_start <= 1'b0;
    rx3_hdr_valid  <= 1'b1;
    rx3_cell_hdr   <= hdr;
    @(posedge aclk);
    rx3_hdr_valid  <= 1'b0;
    #1;
    check("rx3_test_valid", {31'h0, rx3_test_valid}, 32'h1);
    check("rx3_test_cell", {31'h0, rx3_test_cell}, {31'h0, exp_cell});
  endtask : rx_cell

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    num_errors = 0; checked = 0; cycles = 0;
    aresetn = 1'b0; s_axi_awaddr = '0; s_axi_awvalid = 1'b0; s_axi_wdata = '0;
    s_axi_wstrb = 4'h0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0; s_axi_araddr = '0;
    s_axi_arvalid = 1'b0; s_axi_rready = 1'b0; concat_mode = 1'b0;
    tx_cell_start = 4'h0; tx_cell_idle = 4'h0; tx_gen_en = 4'h0;
    rx3_cell_start = 1'b0; rx3_hdr_valid = 1'b0; rx3_cell_hdr = '0;
    rx3_exp_bytes_3_4 = 16'h5566;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    check("tx_test_sel reset", {28'h0, tx_test_sel}, 32'h0);
    for (int i = 8'h37; i <= 8'h3F; i++) begin
      rd_chk(ba(i[7:0]), 32'h0, RESP_OKAY);
    end
    // program every header with distinct bytes; upper data half must be dropped
    for (int n = 0; n < NCH; n++) begin
      exp12[n] = {8'hA0 + n[7:0], 8'hB0 + n[7:0]};
      exp34[n] = {8'hC0 + n[7:0], 8'hD0 + n[7:0]};
      wr_chk(ba(8'h3A - n[7:0]), {16'hFFFF, exp12[n]}, 4'hF, RESP_OKAY);
      wr_chk(ba(8'h3E - n[7:0]), {16'hFFFF, exp34[n]}, 4'hF, RESP_OKAY);
    end
    wr_chk(ba(8'h3F), 32'hFFFF_1122, 4'hF, RESP_OKAY);
    for (int n = 0; n < NCH; n++) begin
      rd_chk(ba(8'h3A - n[7:0]), {16'h0, exp12[n]}, RESP_OKAY);
      rd_chk(ba(8'h3E - n[7:0]), {16'h0, exp34[n]}, RESP_OKAY);
    end
    rd_chk(ba(8'h3F), 32'h0000_1122, RESP_OKAY);
    // byte strobe touches only the low byte
    wr_chk(ba(8'h3A), 32'h0000_3377, 4'h1, RESP_OKAY);
    exp12[0] = 16'hA077;
    rd_chk(ba(8'h3A), {16'h0, exp12[0]}, RESP_OKAY);
    // unmapped places
    wr_chk(ba(8'h36), 32'h0000_FFFF, 4'hF, RESP_SLVERR);
    rd_chk(ba(8'h36), 32'h0, RESP_SLVERR);
    rd_chk(8'h00, 32'h0, RESP_SLVERR);
    // transmit generators in four-channel mode
    tx_cell(4'hF, 4'hF, 4'hF);
    tx_cell(4'h0, 4'hF, 4'h0);
    tx_cell(4'hF, 4'h0, 4'h0);
    tx_cell(4'h5, 4'h3, 4'h1);
    // concatenated mode keeps generator 0 only
    @(posedge aclk);
    concat_mode <= 1'b1;
    tx_cell(4'hF, 4'hF, 4'h1);
    @(posedge aclk);
    concat_mode <= 1'b0;
    tx_cell(4'hF, 4'hF, 4'hF);
    // mid-cell write waits for the next boundary
    wr_chk(ba(8'h38), 32'h0000_9988, 4'hF, RESP_OKAY);
    #1;
    check("tx_test_hdr held", tx_test_hdr[2], {exp12[2], exp34[2]});
    exp12[2] = 16'h9988;
    tx_cell(4'hF, 4'hF, 4'hF);
    // receive analyzer 3 compares all four bytes
    rx_cell(32'h1122_5566, 1'b1);
    rx_cell(32'h1122_5567, 1'b0);
    rx_cell(32'h9122_5566, 1'b0);
    @(posedge aclk);
    concat_mode <= 1'b1;
    rx_cell(32'h1122_5566, 1'b0);
    @(posedge aclk);
    concat_mode <= 1'b0;
    #1;
    check("rx3_test_valid pulse", {31'h0, rx3_test_valid}, 32'h0);
    // mid-run reset clears every programmed header
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    check("tx_test_hdr reset", tx_test_hdr[0], 32'h0);
    rd_chk(ba(8'h3A), 32'h0, RESP_OKAY);
    rd_chk(ba(8'h3F), 32'h0, RESP_OKAY);
    finish_test();
  end

endmodule : atmh_hdr_regs_tb

`default_nettype wire
